/* rtl/dvro_core.sv */
// Purpose: Reference slew, transition offset and overcurrent mask sequencer.
// Assumes: Target and speed inputs come from core-clock logic; commands are whole writes.
// Notes: The reference output wraps; targets must be held steady while a slew runs.
`timescale 1ns/10ps
`default_nettype none
module dvro_core #(
  parameter int REF_W = 9
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_cmd_i,
  input wire logic [dvro_pkg::PARAMS_W-1:0] reg_wdata_i,
  output logic [dvro_pkg::PARAMS_W-1:0] reg_rdata_o,
  input wire logic [REF_W-1:0] target_step_i,
  input wire logic fast_i,
  input wire logic [dvro_pkg::SEL_W-1:0] slow_rate_selector_i,
  output logic [REF_W-1:0] reference_step_o,
  output logic transition_active_o,
  output logic oc_mask_o
);
  import dvro_pkg::*;
  // Refuse widths that cannot carry the filtered offset or overrun the slew logic
  if (REF_W < FOUT_W || REF_W > 16) begin
    $error("REF_W out of range");
  end

  dvro_lpf_if lpf ();
  dvro_lpf u_lpf (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .lpf(lpf)
  );

  logic [PARAMS_W-1:0] params_q, params_d, rdata_q, rdata_d;
  logic [CODE_W-1:0] fast_code_q, fast_code_d, slow_code_q, slow_code_d;
  logic [COEF_W-1:0] coef_q, coef_d;
  logic [5:0] tacc_q, tacc_d;
  logic tick_q, tick_d;
  logic [CODE_W:0] pace_q, pace_d, psum, inc;
  logic [CODE_W-1:0] code_eff, fast_eff, slow_eff;
  logic [SEL_W-1:0] sel_eff;
  logic [REF_W-1:0] ref_q, ref_d, ref_out_q, ref_out_d;
  logic rise_q, rise_d, fast_q, fast_d, step;
  logic signed [OFF_W-1:0] off_q, off_d, off_sel;
  logic [MASK_CNT_W-1:0] mcnt_q, mcnt_d, mask_calc;
  logic [TAU_W-1:0] tau;
  logic [MASK_W-1:0] mcode;
  dvro_state_t st_q, st_d;

  // Command port: writes by code, read data registered; unknown codes read zero
  always_comb begin
    params_d = params_q;
    fast_code_d = fast_code_q;
    slow_code_d = slow_code_q;
    rdata_d = rdata_q;
    if (reg_wr_i && reg_cmd_i == CMD_PARAMS) params_d = reg_wdata_i;
    if (reg_wr_i && reg_cmd_i == CMD_FAST_STEP) fast_code_d = reg_wdata_i[CODE_W-1:0];
    if (reg_wr_i && reg_cmd_i == CMD_SLOW_STEP) slow_code_d = reg_wdata_i[CODE_W-1:0];
    if (reg_rd_i) begin
      case (reg_cmd_i)
        CMD_PARAMS: rdata_d = params_q;
        CMD_FAST_STEP: rdata_d = PARAMS_W'(fast_code_q);
        CMD_SLOW_STEP: rdata_d = PARAMS_W'(slow_code_q);
        default: rdata_d = '0;
      endcase
    end
  end

  assign tau = params_q[TAU_LSB +: TAU_W];
  assign mcode = params_q[MASK_LSB +: MASK_W];
  // coefficient from tau; division only follows a register change
  assign coef_d = COEF_W'(LP_NUM / (BASE_NS + int'(tau)));
  // mask time in cycles, rounded up so the mask never ends early
  assign mask_calc = MASK_CNT_W'((int'(mcode) * MASK_STEP_NS + MASK_FIX_NS + CLK_NS - 1) / CLK_NS);

  // 25 ns timebase as a fractional accumulator: exact on average at 8 ns cycles
  always_comb begin
    tacc_d = tacc_q + 6'(CLK_NS);
    tick_d = 1'b0;
    if (tacc_d >= 6'(BASE_NS)) begin
      tacc_d = tacc_d - 6'(BASE_NS);
      tick_d = 1'b1;
    end
  end

  // zero code behaves as the slowest code
  assign fast_eff = (fast_code_q == '0) ? CODE_MAX : fast_code_q;
  assign slow_eff = (slow_code_q == '0) ? CODE_MAX : slow_code_q;
  // scale is twice the selector; zero would stall the slew, so it acts as one
  assign sel_eff = (slow_rate_selector_i == '0) ? SEL_W'(1) : slow_rate_selector_i;
  assign inc = fast_q ? (CODE_W + 1)'(1) : (CODE_W + 1)'(SCALE_MUL * int'(sel_eff));
  assign code_eff = fast_q ? fast_eff : slow_eff;
  assign psum = pace_q + inc;
  // one step once the paced periods reach the code
  assign step = tick_q && (psum >= (CODE_W + 1)'(code_eff));

  // pick offset field by direction and speed
  always_comb begin
    case ({rise_d, fast_d})
      2'b11: off_sel = params_q[OFF_RISE_FAST_LSB +: OFF_W];
      2'b10: off_sel = params_q[OFF_RISE_SLOW_LSB +: OFF_W];
      2'b01: off_sel = params_q[OFF_FALL_FAST_LSB +: OFF_W];
      default: off_sel = params_q[OFF_FALL_SLOW_LSB +: OFF_W];
    endcase
  end

  // Sequencer: slew to the target, then hold the overcurrent mask
  always_comb begin
    st_d = st_q;
    ref_d = ref_q;
    pace_d = pace_q;
    rise_d = rise_q;
    fast_d = fast_q;
    off_d = off_q;
    mcnt_d = mcnt_q;
    case (st_q)
      ST_IDLE, ST_MASK: begin
        if (st_q == ST_MASK) begin
          mcnt_d = mcnt_q - MASK_CNT_W'(1);
          if (mcnt_q <= MASK_CNT_W'(1)) st_d = ST_IDLE;
        end
        if (target_step_i != ref_q) begin
          st_d = ST_SLEW;
          rise_d = target_step_i > ref_q;
          fast_d = fast_i;
          pace_d = '0;
          // offset applied as the transition starts
          off_d = off_sel;
        end
      end
      ST_SLEW: begin
        if (tick_q) pace_d = psum;
        if (step) begin
          pace_d = (psum - (CODE_W + 1)'(code_eff) >= (CODE_W + 1)'(code_eff)) ?
                   '0 : psum - (CODE_W + 1)'(code_eff);
          ref_d = rise_q ? ref_q + REF_W'(1) : ref_q - REF_W'(1);
        end
        if (ref_d == target_step_i) begin
          st_d = ST_MASK;
          // mask hold count loads as the transition ends
          mcnt_d = mask_calc;
          off_d = '0;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // signed offset in steps added to the reference
    ref_out_d = ref_q + REF_W'(lpf.fout);
  end

  // filter updated once per 25 ns
  assign lpf.update = tick_q;
  assign lpf.target = off_q;
  assign lpf.coef = coef_q;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      params_q <= PARAMS_RST;
      fast_code_q <= CODE_RST;
      slow_code_q <= CODE_RST;
      rdata_q <= '0;
      coef_q <= COEF_W'(LP_NUM / BASE_NS);
      tacc_q <= '0;
      tick_q <= 1'b0;
      pace_q <= '0;
      ref_q <= '0;
      ref_out_q <= '0;
      rise_q <= 1'b0;
      fast_q <= 1'b0;
      off_q <= '0;
      mcnt_q <= '0;
      st_q <= ST_IDLE;
    end else begin
      params_q <= params_d;
      fast_code_q <= fast_code_d;
      slow_code_q <= slow_code_d;
      rdata_q <= rdata_d;
      coef_q <= coef_d;
      tacc_q <= tacc_d;
      tick_q <= tick_d;
      pace_q <= pace_d;
      ref_q <= ref_d;
      ref_out_q <= ref_out_d;
      rise_q <= rise_d;
      fast_q <= fast_d;
      off_q <= off_d;
      mcnt_q <= mcnt_d;
      st_q <= st_d;
    end
  end

  // Outputs straight from flops; the mask covers the slew and the hold after it
  logic act_q, mask_q, act_d, mask_d;
  assign act_d = (st_d == ST_SLEW);
  assign mask_d = (st_d != ST_IDLE);
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      act_q <= 1'b0;
      mask_q <= 1'b0;
    end else begin
      act_q <= act_d;
      mask_q <= mask_d;
    end
  end
  assign transition_active_o = act_q;
  assign oc_mask_o = mask_q;
  assign reference_step_o = ref_out_q;
  assign reg_rdata_o = rdata_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  property p_off_sel;
    (st_q != ST_SLEW && st_d == ST_SLEW && rise_d && fast_d) |=>
      off_q == $past(params_q[OFF_RISE_FAST_LSB +: OFF_W]);
  endproperty
  a_off_sel: assert property (p_off_sel) else $error("rise fast offset not chosen");
  property p_ref_out;
    ##1 ref_out_q == REF_W'($past(ref_q) + REF_W'($past(lpf.fout)));
  endproperty
  a_ref_out: assert property (p_ref_out) else $error("offset not added to reference");
  property p_tau;
    (reg_wr_i && reg_cmd_i == CMD_PARAMS) |=> tau == $past(reg_wdata_i[TAU_LSB +: TAU_W]);
  endproperty
  a_tau: assert property (p_tau) else $error("time constant not stored");
  property p_coef;
    (reg_wr_i && reg_cmd_i == CMD_PARAMS) |=> ##1
      coef_q == COEF_W'(LP_NUM / (BASE_NS + int'($past(tau))));
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient wrong");
  property p_mask_hold;
    $fell(act_q) |-> oc_mask_o;
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask dropped at end");
  property p_mask_len;
    (st_q == ST_SLEW && st_d == ST_MASK) |=> mcnt_q == $past(mask_calc);
  endproperty
  a_mask_len: assert property (p_mask_len) else $error("mask length wrong");
  property p_step_tick;
    $changed(ref_q) |-> $past(tick_q) && $past(st_q) == ST_SLEW;
  endproperty
  a_step_tick: assert property (p_step_tick) else $error("step off the timebase");
  property p_code_zero;
    (slow_code_q == '0) |-> slow_eff == CODE_MAX;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("zero code not wrapped");
  property p_scale;
    (!fast_q && slow_rate_selector_i != '0) |->
      inc == (CODE_W + 1)'(SCALE_MUL * int'(slow_rate_selector_i));
  endproperty
  a_scale: assert property (p_scale) else $error("slow scale wrong");
  property p_off_clear;
    (st_q == ST_SLEW && st_d == ST_MASK) |=> off_q == '0 ##[0:3] lpf.update;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("offset not released");

  c_rise: cover property ($rose(act_q) && rise_q);
  c_fall: cover property ($rose(act_q) && !rise_q);
  c_mask_end: cover property ($fell(oc_mask_o));
endmodule
`default_nettype wire

/* include/dvro_pkg.sv */
// Purpose: Shared constants for the transition offset and overcurrent mask block.
// Assumes: 125 MHz core clock; configuration written through the device command port.
// Notes: Times are kept in ns, cycle counts are derived from them in the logic.
package dvro_pkg;
  // Command codes of the configuration registers
  localparam logic [15:0] CMD_FAST_STEP = 16'hb00c;
  localparam logic [15:0] CMD_SLOW_STEP = 16'hb00d;
  localparam logic [15:0] CMD_PARAMS = 16'hb00e;
  localparam int PARAMS_W = 48;
  // Offset fields, most significant first: rise fast, rise slow, fall fast, fall slow
  localparam int OFF_W = 6;
  localparam int OFF_RISE_FAST_LSB = 42;
  localparam int OFF_RISE_SLOW_LSB = 36;
  localparam int OFF_FALL_FAST_LSB = 30;
  localparam int OFF_FALL_SLOW_LSB = 24;
  localparam int TAU_LSB = 10;
  localparam int TAU_W = 14;
  localparam int MASK_LSB = 0;
  localparam int MASK_W = 10;
  // Step code fields
  localparam int CODE_W = 6;
  localparam logic [CODE_W-1:0] CODE_MAX = 6'h3f;
  localparam int SEL_W = 4;
  localparam int SCALE_MUL = 2;
  // Reset values of the configuration registers
  localparam logic [PARAMS_W-1:0] PARAMS_RST = 48'h0;
  localparam logic [CODE_W-1:0] CODE_RST = 6'h01;
  // Timing
  localparam int CLK_NS = 8;
  localparam int BASE_NS = 25;
  localparam int MASK_STEP_NS = 100;
  localparam int MASK_FIX_NS = 25;
  localparam int LP_FRAC = 14;
  localparam int LP_NUM = BASE_NS * (2 ** LP_FRAC);
  localparam int COEF_W = LP_FRAC + 1;
  localparam int MASK_CNT_W = 14;
  localparam int FOUT_W = 8;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SLEW,
    ST_MASK
  } dvro_state_t;
endpackage

/* include/dvro_lpf_if.sv */
// Purpose: Carrier between the sequencer and the offset low-pass filter.
// Assumes: Both ends run on the core clock.
// Notes: The sequencer drives target, coefficient and update; the filter returns its output.
`timescale 1ns/10ps
`default_nettype none
interface dvro_lpf_if;
  import dvro_pkg::*;
  logic update;
  logic signed [OFF_W-1:0] target;
  logic [COEF_W-1:0] coef;
  logic signed [FOUT_W-1:0] fout;
  modport seq (output update, output target, output coef, input fout);
  modport filt (input update, input target, input coef, output fout);
endinterface
`default_nettype wire

/* rtl/dvro_lpf.sv */
// Purpose: First-order low-pass of the transition offset, in reference steps.
// Assumes: One update pulse per 25 ns period; coefficient over 2^14 is the smoothing fraction per update.
// Notes: State keeps 14 fraction bits so small fractions still converge.
`timescale 1ns/10ps
`default_nettype none
module dvro_lpf (
  input wire logic core_clk_i,
  input wire logic reset_i,
  dvro_lpf_if.filt lpf
);
  import dvro_pkg::*;
  localparam int Y_W = OFF_W + LP_FRAC + 2;
  localparam int P_W = Y_W + 1 + COEF_W + 1;
  logic signed [Y_W-1:0] y_q, y_d;
  logic signed [Y_W:0] diff;
  logic signed [P_W-1:0] prod;
  logic signed [Y_W-1:0] rnd;
  logic signed [FOUT_W-1:0] fout_q, fout_d;

  // Smoothing step y += (x - y) * coef / 2^14, then round to whole steps
  always_comb begin
    diff = (Y_W + 1)'($signed(lpf.target) <<< LP_FRAC) - (Y_W + 1)'(y_q);
    prod = P_W'(diff) * P_W'($signed({1'b0, lpf.coef}));
    y_d = y_q;
    if (lpf.update) begin
      y_d = y_q + Y_W'(prod >>> LP_FRAC);
    end
    rnd = (y_d + Y_W'(2 ** (LP_FRAC - 1))) >>> LP_FRAC;
    fout_d = FOUT_W'(rnd);
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      y_q <= '0;
      fout_q <= '0;
    end else begin
      y_q <= y_d;
      fout_q <= fout_d;
    end
  end

  assign lpf.fout = fout_q;
endmodule
`default_nettype wire

/* test/dvro_far_model.sv */
// Purpose: Far-side model: reference target source and overcurrent monitor.
// Assumes: Core clock only; new targets are asked for while no slew runs.
// Notes: Tallies slew and mask-hold cycles for the bench to judge.
`timescale 1ns/10ps
`default_nettype none
module dvro_far_model #(
  parameter int REF_W = 9
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire logic [REF_W-1:0] req_target_i,
  input wire logic transition_active_i,
  input wire logic oc_mask_i,
  output logic [REF_W-1:0] target_step_o,
  output int slew_cyc_o,
  output int hold_cyc_o
);
  // Target only moves between transitions, since the engine cannot reverse
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      target_step_o <= '0;
      slew_cyc_o <= 0;
      hold_cyc_o <= 0;
    end else if (req_i && !transition_active_i) begin
      target_step_o <= req_target_i;
      slew_cyc_o <= 0;
      hold_cyc_o <= 0;
    end else begin
      if (transition_active_i) slew_cyc_o <= slew_cyc_o + 1;
      if (oc_mask_i && !transition_active_i) hold_cyc_o <= hold_cyc_o + 1;
    end
  end
endmodule
`default_nettype wire

/* test/dvro_core_tb_top.sv */
// Purpose: Self-checking bench for the transition offset and mask block.
// Assumes: Inputs change on the falling edge; 8 ns core clock.
// Notes: Loop step codes act as 0x3f so slews are long enough to sample.
`timescale 1ns/10ps
`default_nettype none
module dvro_core_tb_top;
  import dvro_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_cmd_i = 16'h0;
  logic [PARAMS_W-1:0] reg_wdata_i = '0;
  logic [PARAMS_W-1:0] reg_rdata_o;
  logic [PARAMS_W-1:0] v;
  logic [8:0] target_step_i;
  logic [8:0] reference_step_o;
  logic [8:0] req_target = 9'h0;
  logic fast_i = 1'b0;
  logic req = 1'b0;
  logic transition_active_o;
  logic oc_mask_o;
  logic [SEL_W-1:0] slow_rate_selector_i = 4'h1;
  int slew_cyc, hold_cyc, num_errors = 0, checked = 0, cycles = 0;
  real ec;
  // Mode table: rise fast, rise slow, fall fast, fall slow
  logic [8:0] tgt[4] = '{9'h015, 9'h016, 9'h015, 9'h014};
  logic signed [8:0] ex[4] = '{9'sd3, -9'sd2, -9'sd4, 9'sd0};
  int dir[4] = '{1, 1, -1, -1};
  logic fst[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [3:0] sel[4] = '{4'h1, 4'h1, 4'h1, 4'h3};
  logic [5:0] slw[4] = '{6'h3f, 6'h00, 6'h3f, 6'h3f};
  logic [13:0] tau[4] = '{14'h0, 14'h0, 14'h0, 14'h9ab};

  always #4 core_clk_i = ~core_clk_i;

  dvro_core #(.REF_W(9)) dvro_core_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_cmd_i(reg_cmd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .target_step_i(target_step_i),
    .fast_i(fast_i), .slow_rate_selector_i(slow_rate_selector_i),
    .reference_step_o(reference_step_o), .transition_active_o(transition_active_o),
    .oc_mask_o(oc_mask_o));

  dvro_far_model #(.REF_W(9)) dvro_far_model_inst (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .req_i(req), .req_target_i(req_target),
    .transition_active_i(transition_active_o), .oc_mask_i(oc_mask_o),
    .target_step_o(target_step_i), .slew_cyc_o(slew_cyc), .hold_cyc_o(hold_cyc));

  task automatic complete_run();
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [PARAMS_W-1:0] got, input logic [PARAMS_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] cmd, input logic [PARAMS_W-1:0] d);
    @(negedge core_clk_i);
    reg_cmd_i = cmd;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [15:0] cmd, output logic [PARAMS_W-1:0] d);
    @(negedge core_clk_i);
    reg_cmd_i = cmd;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    @(negedge core_clk_i);
    d = reg_rdata_o;
  endtask

  // Ask for a target, then wait for mask release and the offset to fade
  task automatic settle(input logic [8:0] t);
    int n;
    @(negedge core_clk_i);
    req_target = t;
    req = 1'b1;
    @(negedge core_clk_i);
    req = 1'b0;
    for (n = 0; n < 4000 && !(oc_mask_o === 1'b0 && reference_step_o === t); n++) begin
      @(negedge core_clk_i);
    end
  endtask

  // Bounded hang guard; the whole run needs under a thousand cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    logic [8:0] s;
    logic signed [8:0] d;
    repeat (12) @(negedge core_clk_i);
    reset_i = 1'b0;
    rd(CMD_PARAMS, v);
    chk(v, PARAMS_RST);
    rd(CMD_SLOW_STEP, v);
    chk(v, 48'h1);
    rd(16'hb00f, v);
    chk(v, 48'h0);
    wr(16'hb00f, 48'hffff_ffff_ffff);
    rd(CMD_PARAMS, v);
    chk(v, PARAMS_RST);
    wr(CMD_PARAMS, 48'ha5c3_1234_5678);
    rd(CMD_PARAMS, v);
    chk(v, 48'ha5c3_1234_5678);
    wr(CMD_PARAMS, 48'h0);
    wr(CMD_FAST_STEP, 48'h1);
    // Fast code 1: one step per 25 ns period, twenty steps up, shortest mask
    fast_i = 1'b1;
    settle(9'h014);
    chk(reference_step_o, 48'h14);
    ec = 20.0 * BASE_NS / CLK_NS;
    chk((slew_cyc < ec + 4.0) && (slew_cyc > ec - 4.0), 1'b1);
    chk(hold_cyc, (MASK_FIX_NS + CLK_NS - 1) / CLK_NS);
    wr(CMD_FAST_STEP, 48'h3f);
    rd(CMD_FAST_STEP, v);
    chk(v, 48'h3f);
    for (int i = 0; i < 4; i++) begin
      wr(CMD_PARAMS, {6'h03, 6'h3e, 6'h3c, 6'h05, tau[i], 10'(i + 1)});
      wr(CMD_SLOW_STEP, {42'h0, slw[i]});
      @(negedge core_clk_i);
      fast_i = fst[i];
      slow_rate_selector_i = sel[i];
      s = reference_step_o;
      fork
        settle(tgt[i]);
        begin
          wait (transition_active_o === 1'b1);
          repeat (10) @(negedge core_clk_i);
          d = reference_step_o - s;
          chk(oc_mask_o, 1'b1);
          chk((d == ex[i]) || (d == ex[i] + dir[i]), 1'b1);
        end
      join
      chk(reference_step_o, tgt[i]);
      ec = 1575.0 / (fst[i] ? 1.0 : 2.0 * sel[i]) / 8.0;
      chk((slew_cyc < ec + 4.0) && (slew_cyc > ec - 4.0), 1'b1);
      chk(hold_cyc, ((i + 1) * 100 + 25 + 7) / 8);
    end
    // Reset in mid-run: outputs and registers fall back to reset values
    @(negedge core_clk_i);
    reset_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    reset_i = 1'b0;
    chk(reference_step_o, 48'h0);
    chk(oc_mask_o, 1'b0);
    rd(CMD_PARAMS, v);
    chk(v, PARAMS_RST);
    complete_run();
  end
endmodule
`default_nettype wire
